// File: include/irfts_pkg.sv
package irfts_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IRFTS_IDX_FIFO_TIMEOUT_CONTROL = 8'h06;
  localparam logic [7:0] IRFTS_IDX_TRANSFER_ACTIVITY_STATUS = 8'h07;
  localparam logic [7:0] IRFTS_IDX_IRQ_STATUS = 8'h08;
  localparam logic [7:0] IRFTS_IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IRFTS_IDX_MODE_CONTROL = 8'h0A;
  localparam logic [11:0] IRFTS_ADDR_FIFO_TIMEOUT_CONTROL = {2'h0, IRFTS_IDX_FIFO_TIMEOUT_CONTROL, 2'h0};
  localparam logic [11:0] IRFTS_ADDR_TRANSFER_ACTIVITY_STATUS = {2'h0, IRFTS_IDX_TRANSFER_ACTIVITY_STATUS, 2'h0};
  localparam logic [11:0] IRFTS_ADDR_IRQ_STATUS = {2'h0, IRFTS_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] IRFTS_ADDR_IRQ_MASK = {2'h0, IRFTS_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] IRFTS_ADDR_MODE_CONTROL = {2'h0, IRFTS_IDX_MODE_CONTROL, 2'h0};

  // fifo_timeout_control fields
  localparam int IRFTS_TIMEOUT_LSB = 0;
  localparam int IRFTS_THRESHOLD_LSB = 8;
  localparam int IRFTS_PTR_CLEAR_BIT = 15;
  localparam logic [7:0] IRFTS_TIMEOUT_RESET = 8'h0A;
  localparam logic [6:0] IRFTS_THRESHOLD_RESET = 7'h40;
  // transfer_activity_status fields
  localparam int IRFTS_TX_ACTIVE_BIT = 0;
  localparam int IRFTS_RX_ACTIVE_BIT = 1;
  localparam logic [13:0] IRFTS_RESERVED_RESET = 14'h000A;
  // Interrupt status bits
  localparam int IRFTS_IRQ_TIMEOUT_BIT = 0;
  localparam int IRFTS_IRQ_THRESHOLD_BIT = 1;
  localparam int IRFTS_IRQ_WIDTH = 2;
  // mode_control: bit 0 selects slow infrared rates
  localparam int IRFTS_SLOW_MODE_BIT = 0;
  localparam logic IRFTS_SLOW_MODE_RESET = 1'b1;

  // Timing
  localparam int IRFTS_CLK_HZ = 50_000_000;
  localparam int IRFTS_TIMEOUT_UNIT_MS = 50;
  localparam int IRFTS_UNIT_CYCLES = IRFTS_CLK_HZ / 1000 * IRFTS_TIMEOUT_UNIT_MS;
endpackage

// File: hdl/irfts_top.sv
// Operation
// - An 8-bit receive timeout resets to 0x0A and value N means N times 50 ms; a value of zero also gives 50 ms.
// - In slow rate mode a reception is aborted once the receive line stays idle for the timeout period.
// - Writing one to bit 15 clears the FIFO pointers and the bit then returns to zero by itself.
// - Read-only status bit 0 is one while a transmission is under way, reset zero.
// - Read-only status bit 1 is one while a reception is under way, reset zero.
module irfts_top
  import irfts_pkg::*;
#(
  parameter int UNIT_CYCLES = IRFTS_UNIT_CYCLES,
  parameter int LEVEL_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  input wire logic rx_start,
  input wire logic rx_done,
  input wire logic tx_busy,
  input wire logic [LEVEL_W-1:0] fifo_level,
  output logic fifo_ptr_clear,
  output logic rx_abort,
  output logic fifo_threshold_hit,
  output logic irq
);
  typedef enum logic [0:0] {IRFTS_RX_IDLE, IRFTS_RX_BUSY} irfts_rx_t;

  logic rx_meta_q, rx_sync_q, rx_prev_q;
  logic [7:0] timeout_q, timeout_d;
  logic [6:0] threshold_q, threshold_d;
  logic clear_q, clear_d;
  logic slow_q, slow_d;
  logic [IRFTS_IRQ_WIDTH-1:0] ists_q, ists_d, imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  irfts_rx_t rx_state_q, rx_state_d;
  logic [31:0] unit_cnt_q, unit_cnt_d;
  logic [7:0] units_q, units_d;
  logic abort_q, abort_d;
  logic tx_act_q, tx_act_d, rx_act_q, rx_act_d;
  logic hit_q, hit_d;
  logic wr, rd, hit_evt, tmo_evt, valid_addr;

  assign wr = psel && penable && pwrite && !pready_q;
  assign rd = psel && penable && !pwrite && !pready_q;
  assign valid_addr = paddr == IRFTS_ADDR_FIFO_TIMEOUT_CONTROL || paddr == IRFTS_ADDR_TRANSFER_ACTIVITY_STATUS
    || paddr == IRFTS_ADDR_IRQ_STATUS || paddr == IRFTS_ADDR_IRQ_MASK || paddr == IRFTS_ADDR_MODE_CONTROL;

  // Receive line is asynchronous to pclk; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (clk_en) begin
      rx_meta_q <= rx_line;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // Reception tracking and idle timeout
  always_comb begin
    rx_state_d = rx_state_q;
    unit_cnt_d = unit_cnt_q;
    units_d = units_q;
    abort_d = 1'b0;
    tmo_evt = 1'b0;
    case (rx_state_q)
      IRFTS_RX_IDLE: begin
        unit_cnt_d = '0;
        units_d = '0;
        if (rx_start) begin
          rx_state_d = IRFTS_RX_BUSY;
        end
      end
      IRFTS_RX_BUSY: begin
        if (rx_done) begin
          rx_state_d = IRFTS_RX_IDLE;
        end else if (rx_sync_q != rx_prev_q || !slow_q) begin
          // Any line activity restarts the idle window; fast rates never time out
          unit_cnt_d = '0;
          units_d = '0;
        end else if (unit_cnt_q == 32'(UNIT_CYCLES - 1)) begin
          unit_cnt_d = '0;
          units_d = units_q + 8'h01;
          if (units_q + 8'h01 >= timeout_q) begin
            abort_d = 1'b1;
            tmo_evt = 1'b1;
            rx_state_d = IRFTS_RX_IDLE;
          end
        end else begin
          unit_cnt_d = unit_cnt_q + 32'h0000_0001;
        end
      end
      default: rx_state_d = IRFTS_RX_IDLE;
    endcase
    rx_act_d = rx_state_d == IRFTS_RX_BUSY;
    tx_act_d = tx_busy;
    hit_d = fifo_level >= LEVEL_W'(threshold_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= IRFTS_RX_IDLE;
      unit_cnt_q <= '0;
      units_q <= '0;
      abort_q <= 1'b0;
      rx_act_q <= 1'b0;
      tx_act_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (clk_en) begin
      rx_state_q <= rx_state_d;
      unit_cnt_q <= unit_cnt_d;
      units_q <= units_d;
      abort_q <= abort_d;
      rx_act_q <= rx_act_d;
      tx_act_q <= tx_act_d;
      hit_q <= hit_d;
    end
  end

  assign hit_evt = hit_d && !hit_q;

  // Register file and APB slave; one wait state, answer on the second access cycle
  always_comb begin
    timeout_d = timeout_q;
    threshold_d = threshold_q;
    clear_d = 1'b0;
    slow_d = slow_q;
    imask_d = imask_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    // Set wins over a same-cycle write-one-to-clear
    ists_d = ists_q;
    if (wr && paddr == IRFTS_ADDR_IRQ_STATUS && pstrb[0]) begin
      ists_d = ists_q & ~pwdata[IRFTS_IRQ_WIDTH-1:0];
    end
    if (tmo_evt) begin
      ists_d[IRFTS_IRQ_TIMEOUT_BIT] = 1'b1;
    end
    if (hit_evt) begin
      ists_d[IRFTS_IRQ_THRESHOLD_BIT] = 1'b1;
    end
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = !valid_addr;
    end
    if (wr) begin
      case (paddr)
        IRFTS_ADDR_FIFO_TIMEOUT_CONTROL: begin
          if (pstrb[0]) begin
            timeout_d = pwdata[IRFTS_TIMEOUT_LSB +: 8];
          end
          if (pstrb[1]) begin
            threshold_d = pwdata[IRFTS_THRESHOLD_LSB +: 7];
            clear_d = pwdata[IRFTS_PTR_CLEAR_BIT];
          end
        end
        IRFTS_ADDR_IRQ_MASK: begin
          if (pstrb[0]) begin
            imask_d = pwdata[IRFTS_IRQ_WIDTH-1:0];
          end
        end
        IRFTS_ADDR_MODE_CONTROL: begin
          if (pstrb[0]) begin
            slow_d = pwdata[IRFTS_SLOW_MODE_BIT];
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr)
        // Pointer clear always reads zero since it self-clears after one cycle
        IRFTS_ADDR_FIFO_TIMEOUT_CONTROL: prdata_d = {16'h0000, 1'b0, threshold_q, timeout_q};
        IRFTS_ADDR_TRANSFER_ACTIVITY_STATUS: prdata_d = {16'h0000, IRFTS_RESERVED_RESET, rx_act_q, tx_act_q};
        IRFTS_ADDR_IRQ_STATUS: prdata_d = {30'h0000_0000, ists_q};
        IRFTS_ADDR_IRQ_MASK: prdata_d = {30'h0000_0000, imask_q};
        IRFTS_ADDR_MODE_CONTROL: prdata_d = {31'h0000_0000, slow_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(ists_d & imask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= IRFTS_TIMEOUT_RESET;
      threshold_q <= IRFTS_THRESHOLD_RESET;
      clear_q <= 1'b0;
      slow_q <= IRFTS_SLOW_MODE_RESET;
      ists_q <= '0;
      imask_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      timeout_q <= timeout_d;
      threshold_q <= threshold_d;
      clear_q <= clear_d;
      slow_q <= slow_d;
      ists_q <= ists_d;
      imask_q <= imask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fifo_ptr_clear = clear_q;
  assign rx_abort = abort_q;
  assign fifo_threshold_hit = hit_q;
  assign irq = irq_q;
endmodule // irfts_top

// File: sim/irfts_assertions.sv
module irfts_assertions
  import irfts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rx_line,
  input wire logic tx_busy,
  input wire logic fifo_ptr_clear,
  input wire logic rx_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_wr;
  logic sr;
  assign clr_wr = pready && pwrite && pwdata[15] && pstrb[1] && paddr == IRFTS_ADDR_FIFO_TIMEOUT_CONTROL;
  assign sr = pready && !pwrite && paddr == IRFTS_ADDR_TRANSFER_ACTIVITY_STATUS;
  AST_CLR_CAUSE: assert property (fifo_ptr_clear |-> clr_wr) else $error("stray clear");
  AST_CLR_FIRE: assert property (clr_wr |-> fifo_ptr_clear) else $error("no clear");
  AST_CLR_SELF: assert property (fifo_ptr_clear |=> !fifo_ptr_clear) else $error("clear stuck");
  AST_ABORT_ONE: assert property (rx_abort |=> !rx_abort) else $error("long abort");
  // Edges reach the idle counter late, so twelve quiet cycles is a safe floor
  AST_ABORT_IDLE: assert property (rx_abort |-> rx_line == $past(rx_line, 12)) else $error("busy abort");
  // Read data carries the flag sampled two edges before pready is seen
  AST_TX_FLAG: assert property (sr && $stable(tx_busy) && tx_busy == $past(tx_busy, 2) |-> prdata[0] == tx_busy)
    else $error("bad tx flag");
endmodule // irfts_assertions
bind irfts_top irfts_assertions u_chk (.pclk, .presetn, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .rx_line,
  .tx_busy, .fifo_ptr_clear, .rx_abort);

// File: sim/irfts_xcvr_model.sv
module irfts_xcvr_model (
  input wire logic pclk,
  output logic rx_line,
  output logic rx_start,
  output logic rx_done,
  output logic tx_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rx_line, rx_start, rx_done, tx_busy} = 4'h8;
  // Edges four cycles apart stay well inside the shortest idle window
  task automatic rx_frame(input int edges, input logic fin);
    @(posedge pclk) rx_start <= 1'h1;
    @(posedge pclk) rx_start <= 1'h0;
    repeat (edges) begin
      repeat (3) @(posedge pclk);
      @(posedge pclk) rx_line <= ~rx_line;
    end
    if (fin) begin
      @(posedge pclk) rx_done <= 1'h1;
      @(posedge pclk) rx_done <= 1'h0;
    end
  endtask
  task automatic tx_burst(input int n);
    @(posedge pclk) tx_busy <= 1'h1;
    repeat (n) @(posedge pclk);
    tx_busy <= 1'h0;
  endtask
endmodule // irfts_xcvr_model

// File: sim/ir_fifo_timeout_status_test.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t %0h %0h", $time, a, e); end end
module ir_fifo_timeout_status_test
  import irfts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] FTC = IRFTS_ADDR_FIFO_TIMEOUT_CONTROL;
  localparam logic [11:0] ST = IRFTS_ADDR_TRANSFER_ACTIVITY_STATUS;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, rerr, rx_line, rx_start, rx_done, tx_busy, hit, irq, rx_abort;
  logic ptr_clr, rclr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [6:0] lvl;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;
  always #10 pclk = ~pclk;
  irfts_xcvr_model xcvr (.pclk, .rx_line, .rx_start, .rx_done, .tx_busy);
  irfts_top #(.UNIT_CYCLES(10)) dut (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .rx_line, .rx_start, .rx_done, .tx_busy, .fifo_level(lvl),
    .fifo_ptr_clear(ptr_clr), .rx_abort, .fifo_threshold_hit(hit), .irq);
  task automatic tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    rclr = ptr_clr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // The whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lvl} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, FTC, 32'h0);
    `CHK(rdata, 32'h400A)
    `CHK(rerr, 1'h0)
    apb(1'h0, ST, 32'h0);
    `CHK(rdata, 32'h28)
    apb(1'h0, 12'h3C, 32'h0);
    `CHK(rerr, 1'h1)
    apb(1'h1, IRFTS_ADDR_IRQ_MASK, 32'h0);
    fork
      xcvr.tx_burst(8);
      begin
        repeat (2) @(posedge pclk);
        apb(1'h0, ST, 32'h0);
      end
    join
    `CHK(rdata, 32'h29)
    for (int t = 1; t <= 2; t++) begin
      apb(1'h1, FTC, 32'h8500 | t);
      `CHK(rclr, 1'h1)
      apb(1'h0, FTC, 32'h0);
      `CHK(rdata, 32'h500 | t)
      `CHK(rclr, 1'h0)
      xcvr.rx_frame(4, 1'h0);
      t0 = cyc;
      apb(1'h0, ST, 32'h0);
      `CHK(rdata, 32'h2A)
      while (rx_abort !== 1'h1) @(posedge pclk);
      `CHK(cyc - t0 >= t * 10 && cyc - t0 <= t * 10 + 6, 1'h1)
    end
    `CHK(irq, 1'h0)
    apb(1'h1, IRFTS_ADDR_IRQ_MASK, 32'h1);
    apb(1'h0, IRFTS_ADDR_IRQ_STATUS, 32'h0);
    `CHK({irq, rdata}, 33'h100000001)
    apb(1'h1, IRFTS_ADDR_IRQ_STATUS, 32'h1);
    xcvr.rx_frame(2, 1'h1);
    apb(1'h0, ST, 32'h0);
    `CHK({irq, rdata}, 33'h28)
    repeat (30) @(posedge pclk);
    apb(1'h0, IRFTS_ADDR_IRQ_STATUS, 32'h0);
    `CHK(rdata, 32'h0)
    // Fast rates must ride out a quiet spell at least twice as long as the timeout
    apb(1'h1, IRFTS_ADDR_MODE_CONTROL, 32'h0);
    xcvr.rx_frame(0, 1'h0);
    repeat (40) @(posedge pclk);
    apb(1'h0, ST, 32'h0);
    `CHK(rdata, 32'h2A)
    apb(1'h0, IRFTS_ADDR_IRQ_STATUS, 32'h0);
    `CHK(rdata, 32'h0)
    apb(1'h1, IRFTS_ADDR_MODE_CONTROL, 32'h1);
    while (rx_abort !== 1'h1) @(posedge pclk);
    `CHK(irq, 1'h1)
    apb(1'h1, IRFTS_ADDR_IRQ_STATUS, 32'h1);
    @(posedge pclk) lvl <= 7'h5;
    repeat (3) @(posedge pclk);
    `CHK(hit, 1'h1)
    lvl <= 7'h4;
    repeat (3) @(posedge pclk);
    `CHK(hit, 1'h0)
    apb(1'h0, IRFTS_ADDR_IRQ_STATUS, 32'h0);
    `CHK({irq, rdata}, 33'h2)
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, FTC, 32'h0);
    `CHK(rdata, 32'h400A)
    apb(1'h0, ST, 32'h0);
    `CHK(rdata, 32'h28)
    tally_and_finish();
  end
endmodule // ir_fifo_timeout_status_test
